// ### rtl/spi_slave_port.sv
// Functional notes
// - Mode 0 only, clock idles low
// - Sample on rise, change on fall
// - Host frames transaction with select low
// - Whole bytes; partial byte dropped
// - Command MSB: 1 write, 0 read
// - Low seven bits give start address
// - Write bytes go to addressed register
// - Outgoing line meaningless during writes
// - Host adds two rising edges after write
// - Host may use scratch read for edges
// - Read ignores input after command
// - Two fillers, then register data bytes
// - Reads need no trailing edges
// - Most significant bit first always
// - Only the controller port is reached
// - Address advances after each byte
// - Packet FIFO addresses hold; writes ignored
// - Command 0xFF returns identification byte
//
// Purpose: Device end of the serial register port
// Assumes: Link pins asynchronous to hclk, sclk at least 8 hclk per half
// Notes: Write bytes pass a small FIFO towards the controller
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps

module byte_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
   } fifo_state_t;
   fifo_state_t s_q;
   fifo_state_t s_d;
   logic push;
   logic pop;

   assign in_ready = (s_q.count != (PW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data = s_q.mem[s_q.rd_ptr];

   // =====================================================
   // Next state
   always_comb begin
      s_d = s_q;
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr = (s_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_d.rd_ptr = (s_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 1'b1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : byte_fifo

module spi_slave_port
   import spi_port_pkg::*;
#(
   parameter logic [7:0] DEV_ID = 8'h5a, // Arbitrary value
   parameter int WR_DEPTH = FIFO_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   spi_link_if.dev link,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [6:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_room,
   output logic rd_req,
   output logic [6:0] rd_addr,
   input wire logic [7:0] rd_data
);
   typedef struct packed {
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic sel_m;
      logic sel_s;
      logic mosi_m;
      logic mosi_s;
      phase_t phase;
      logic [2:0] bit_cnt;
      logic [6:0] rx;
      logic [6:0] addr;
      logic [1:0] fill;
      logic [7:0] tx;
      logic [7:0] rd_buf;
      logic rd_pend;
      logic rd_req;
      logic push;
      logic [14:0] push_word;
      logic miso;
   } dev_state_t;
   dev_state_t s_q;
   dev_state_t s_d;
   logic rise;
   logic fall;
   logic [7:0] byte_v;
   logic [6:0] addr_next;

   assign link.miso = s_q.miso;
   assign rd_req = s_q.rd_req;
   assign rd_addr = s_q.addr;

   // =====================================================
   // Write path buffer
   byte_fifo #(.WIDTH(15), .DEPTH(WR_DEPTH)) u_wr_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_valid(s_q.push),
      .in_ready(wr_room),
      .in_data(s_q.push_word),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data({wr_addr, wr_data})
   );

   // =====================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.sclk_m = link.sclk;
      s_d.sclk_s = s_q.sclk_m;
      s_d.sclk_p = s_q.sclk_s;
      s_d.sel_m = ~link.cs_n;
      s_d.sel_s = s_q.sel_m;
      s_d.mosi_m = link.mosi;
      s_d.mosi_s = s_q.mosi_m;
      s_d.rd_req = 1'b0;
      s_d.push = 1'b0;
      s_d.rd_pend = s_q.rd_req;
      rise = s_q.sclk_s & ~s_q.sclk_p;
      fall = ~s_q.sclk_s & s_q.sclk_p;
      byte_v = {s_q.rx, s_q.mosi_s};
      if (s_q.addr >= PKT_FIFO_FIRST && s_q.addr <= PKT_FIFO_LAST) begin
         addr_next = s_q.addr;
      end else begin
         addr_next = s_q.addr + 7'h01;
      end
      if (s_q.rd_pend) begin
         s_d.rd_buf = rd_data;
      end
      if (!s_q.sel_s) begin
         s_d.phase = PH_CMD;
         s_d.bit_cnt = '0;
         s_d.fill = '0;
         s_d.tx = '0;
         s_d.miso = 1'b0;
      end else begin
         if (rise) begin
            s_d.rx = {s_q.rx[5:0], s_q.mosi_s};
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == BIT_LAST) begin
               case (s_q.phase)
                  PH_CMD: begin
                     s_d.fill = '0;
                     s_d.addr = byte_v[6:0];
                     if (byte_v == ID_CMD) begin
                        s_d.phase = PH_ID;
                     end else if (byte_v[7]) begin
                        s_d.phase = PH_WRITE;
                     end else begin
                        s_d.phase = PH_READ;
                        s_d.rd_req = 1'b1;
                     end
                  end
                  PH_WRITE: begin
                     if (addr_next != s_q.addr) begin
                        s_d.push = 1'b1;
                        s_d.push_word = {s_q.addr, byte_v};
                     end
                     s_d.addr = addr_next;
                  end
                  default: begin
                  end
               endcase
            end
         end
         if (fall) begin
            if (s_q.bit_cnt == 3'h0) begin
               case (s_q.phase)
                  PH_READ: begin
                     if (s_q.fill < FILLER_COUNT) begin
                        s_d.tx = FILLER_BYTE;
                        s_d.fill = s_q.fill + 2'h1;
                     end else begin
                        s_d.tx = s_q.rd_buf;
                        s_d.addr = addr_next;
                        s_d.rd_req = 1'b1;
                     end
                  end
                  PH_ID: begin
                     s_d.tx = (s_q.fill == 2'h0) ? DEV_ID : FILLER_BYTE;
                     s_d.fill = 2'h1;
                  end
                  default: begin
                     s_d.tx = FILLER_BYTE;
                  end
               endcase
               s_d.miso = s_d.tx[7];
            end else begin
               s_d.tx = {s_q.tx[6:0], 1'b0};
               s_d.miso = s_q.tx[6];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : spi_slave_port

// ### rtl/spi_port_pkg.sv
// Purpose: Shared constants and types for the serial register port and its host
// Assumes: 100 MHz hclk
// Notes: Host register offsets are byte addresses on AHB-Lite
package spi_port_pkg;
   // =====================================================
   // Link framing
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] ID_CMD = 8'hff;
   localparam logic [7:0] FILLER_BYTE = 8'h00;
   localparam logic [1:0] FILLER_COUNT = 2'h2;
   localparam logic [6:0] PKT_FIFO_FIRST = 7'h70;
   localparam logic [6:0] PKT_FIFO_LAST = 7'h73;
   localparam logic [1:0] TRAIL_EDGES = 2'h2;
   localparam int FIFO_DEPTH = 4;
   // =====================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_HALF_NS = 80;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =====================================================
   // Host register map
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_TX = 8'h04;
   localparam logic [7:0] OFS_RX = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   // =====================================================
   // State encodings
   typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ, PH_ID} phase_t;
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TRAIL} host_state_t;
endpackage : spi_port_pkg

// ### rtl/spi_link_if.sv
// Purpose: Four-wire serial link between host and register port
// Assumes: Mode 0 framing
// Notes: No clocking block; bench joins the ends
`timescale 1ns/10ps
interface spi_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if

// ### rtl/spi_host_master.sv
// Purpose: Host end, serial master driven by AHB-Lite registers
// Assumes: Single word AHB-Lite transfers, 100 MHz hclk
// Notes: Serial clock is divided from hclk
`timescale 1ns/10ps
module spi_host_master
   import spi_port_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   spi_link_if.host link
);
   typedef struct packed {
      host_state_t state;
      logic [7:0] div;
      logic sclk;
      logic csn;
      logic mosi;
      logic go;
      logic [7:0] cmd;
      logic [7:0] left;
      logic [7:0] tx;
      logic [3:0] bit_cnt;
      logic [7:0] rx;
      logic [31:0] txw;
      logic [31:0] rxw;
      logic [1:0] trail;
      logic miso_m;
      logic miso_s;
      logic ah_valid;
      logic ah_we;
      logic [7:0] ah_addr;
      logic [31:0] rdata;
   } host_reg_t;
   host_reg_t s_q;
   host_reg_t s_d;
   logic tick;
   logic busy;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign link.sclk = s_q.sclk;
   assign link.cs_n = s_q.csn;
   assign link.mosi = s_q.mosi;

   // =====================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.miso_m = link.miso;
      s_d.miso_s = s_q.miso_m;
      tick = (s_q.div == 8'(HALF_CYC - 1));
      s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
      busy = (s_q.state != H_IDLE) | s_q.go;
      // AHB address phase
      s_d.ah_valid = hsel & htrans[1] & hready;
      s_d.ah_we = hwrite;
      s_d.ah_addr = haddr[7:0];
      case (haddr[7:0])
         OFS_CMD: s_d.rdata = {16'h0000, s_q.left, s_q.cmd};
         OFS_TX: s_d.rdata = s_q.txw;
         OFS_RX: s_d.rdata = s_q.rxw;
         OFS_STAT: s_d.rdata = {31'h00000000, busy};
         default: s_d.rdata = 32'h00000000;
      endcase
      // AHB data phase
      if (s_q.ah_valid && s_q.ah_we) begin
         if (s_q.ah_addr == OFS_CMD && !busy) begin
            s_d.cmd = hwdata[7:0];
            s_d.left = hwdata[15:8];
            s_d.go = 1'b1;
         end else if (s_q.ah_addr == OFS_TX && !busy) begin
            s_d.txw = hwdata;
         end
      end
      case (s_q.state)
         H_IDLE: begin
            if (s_q.go && tick) begin
               s_d.go = 1'b0;
               s_d.state = H_SHIFT;
               s_d.csn = 1'b0;
               s_d.tx = s_q.cmd;
               s_d.mosi = s_q.cmd[7];
               s_d.bit_cnt = 4'h0;
            end
         end
         H_SHIFT: begin
            if (tick) begin
               if (!s_q.sclk) begin
                  s_d.sclk = 1'b1;
                  s_d.rx = {s_q.rx[6:0], s_q.miso_s};
                  s_d.bit_cnt = s_q.bit_cnt + 4'h1;
               end else begin
                  s_d.sclk = 1'b0;
                  if (s_q.bit_cnt == BITS_PER_BYTE) begin
                     s_d.rxw = {s_q.rxw[23:0], s_q.rx};
                     s_d.bit_cnt = 4'h0;
                     if (s_q.left == 8'h00) begin
                        s_d.csn = 1'b1;
                        s_d.mosi = 1'b0;
                        s_d.trail = 2'h0;
                        if (s_q.cmd[7] && s_q.cmd != ID_CMD) begin
                           s_d.state = H_TRAIL;
                        end else begin
                           s_d.state = H_IDLE;
                        end
                     end else begin
                        s_d.tx = s_q.txw[31:24];
                        s_d.txw = {s_q.txw[23:0], 8'h00};
                        s_d.mosi = s_q.txw[31];
                        s_d.left = s_q.left - 8'h01;
                     end
                  end else begin
                     s_d.tx = {s_q.tx[6:0], 1'b0};
                     s_d.mosi = s_q.tx[6];
                  end
               end
            end
         end
         H_TRAIL: begin
            if (tick) begin
               s_d.sclk = ~s_q.sclk;
               if (s_q.sclk) begin
                  s_d.trail = s_q.trail + 2'h1;
                  if (s_q.trail == TRAIL_EDGES - 2'h1) begin
                     s_d.state = H_IDLE;
                  end
               end
            end
         end
         default: begin
            s_d.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.csn <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : spi_host_master

// ### testbench/spi_link_properties.sv
// Purpose: Link checker for the serial register port
// Assumes: Link pins sampled on hclk
// Notes: Counts rising edges per frame
`timescale 1ns/10ps
module spi_link_properties #(
   parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary value
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic sclk_q;
   logic [7:0] cnt_q;
   logic [7:0] cmd_q;
   logic rise;
   logic wrf;
   assign rise = sclk && !sclk_q;
   assign wrf = cmd_q[7] && cmd_q != 8'hff && cnt_q >= 8'h8;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_q <= 1'b0;
         cnt_q <= 8'h0;
         cmd_q <= 8'h0;
      end else begin
         sclk_q <= sclk;
         if (cs_n) cnt_q <= 8'h0;
         else if (rise && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h1;
         if (!cs_n && rise && cnt_q < 8'h8) cmd_q <= {cmd_q[6:0], mosi};
      end
   end
   // ======
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_select_clock_low: assert property ($fell(cs_n) |-> !sclk)
      else $error("clock high at select");
   a_idle_after_read: assert property ($rose(cs_n) && !wrf |-> !sclk [*8])
      else $error("clock runs after read");
   a_mosi_hold_high: assert property (!cs_n && sclk |-> $stable(mosi))
      else $error("mosi moved while clock high");
   a_miso_hold_high: assert property (!cs_n && sclk |-> $stable(miso))
      else $error("miso moved while clock high");
   a_whole_bytes: assert property ($rose(cs_n) |-> cnt_q[2:0] == 3'h0)
      else $error("frame not whole bytes");
   a_write_miso_zero: assert property (rise && !cs_n && wrf |-> !miso)
      else $error("miso set in write");
   a_filler_bytes: assert property (rise && !cs_n && !cmd_q[7] && cnt_q >= 8'h8 &&
      cnt_q < 8'h18 |-> !miso)
      else $error("filler not zero");
   a_id_msb_first: assert property (rise && !cs_n && cmd_q == 8'hff &&
      cnt_q >= 8'h8 && cnt_q < 8'h10 |-> miso == DEV_ID[3'h7 - cnt_q[2:0]])
      else $error("id bit wrong");
   a_trail_edges: assert property ($rose(cs_n) && wrf |-> ##[1:60] rise ##[1:60] rise)
      else $error("no trailing edges");
   c_write: cover property ($rose(cs_n) && wrf);
   c_id: cover property (rise && cmd_q == 8'hff && cnt_q == 8'h8);
   c_read: cover property ($rose(cs_n) && !cmd_q[7] && cnt_q >= 8'h28);
endmodule : spi_link_properties

// ### testbench/testbench.sv
// Purpose: Bench joining host end and register port
// Assumes: Controller modelled as byte array
// Notes: Random traffic from fixed seed
`timescale 1ns/10ps
module testbench;
   import spi_port_pkg::*;
   localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, wr_valid, wr_room, rd_req;
   logic [31:0] hrdata;
   logic wr_ready = 1'b0;
   logic [6:0] wr_addr, rd_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data = 8'h0;
   logic [7:0] regs [128];
   logic [7:0] exp_reg [128];
   logic [14:0] exp_q [$];
   logic [31:0] lfsr_q = 32'hd14b;
   logic [31:0] rr_q = 32'hd14b;
   logic stall = 1'b0;
   int bad_count = 0;
   int tests_run = 0;
   // ======
   // Ends and checker
   always #5 hclk = ~hclk;
   spi_link_if link();
   spi_host_master #(.HALF_CYC(8)) u_spi_host_master (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(link));
   spi_slave_port #(.DEV_ID(DEV_ID), .WR_DEPTH(4)) u_spi_slave_port (.hclk(hclk),
      .hresetn(hresetn), .link(link), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_room(wr_room), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data));
   spi_link_properties #(.DEV_ID(DEV_ID)) u_spi_link_properties (.hclk(hclk),
      .hresetn(hresetn), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
      .miso(link.miso));
   // ======
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic fifo_adr(input logic [6:0] a);
      return a >= PKT_FIFO_FIRST && a <= PKT_FIFO_LAST;
   endfunction : fifo_adr
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hresp === 1'b0, "bad response");
   endtask : ahb
   task automatic frame(input logic [7:0] cmd, input logic [7:0] n, input logic [31:0] tx,
      output logic [31:0] rx);
      logic [31:0] st;
      ahb(1'b1, OFS_TX, tx, st);
      ahb(1'b1, OFS_CMD, {16'h0, n, cmd}, st);
      st = 32'h1;
      for (int i = 0; i < 3000 && st[0] !== 1'b0; i++) ahb(1'b0, OFS_STAT, 32'h0, st);
      check(st[0] === 1'b0, "host stuck busy");
      ahb(1'b0, OFS_RX, 32'h0, rx);
   endtask : frame
   task automatic wr_test(input logic [6:0] a, input logic [2:0] n, input logic [31:0] tx);
      logic [31:0] rx;
      logic [6:0] x;
      x = a;
      for (int i = 0; i < n; i++) begin
         if (!fifo_adr(x)) begin
            exp_q.push_back({x, tx[31-8*i -: 8]});
            exp_reg[x] = tx[31-8*i -: 8];
            x++;
         end
      end
      frame({1'b1, a}, {5'h0, n}, tx, rx);
   endtask : wr_test
   task automatic drain(input string s);
      for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(posedge hclk);
      check(exp_q.size() == 0, "write lost");
      $display("%s done", s);
   endtask : drain
   task automatic rd_test(input logic [6:0] a);
      logic [31:0] rx;
      logic [31:0] ex;
      logic [6:0] x;
      x = a;
      ex = 32'h0;
      for (int i = 0; i < 3; i++) begin
         ex = {ex[23:0], exp_reg[x]};
         if (!fifo_adr(x)) x++;
      end
      frame({1'b0, a}, 8'h5, lfsr_q, rx);
      check(rx === ex, "read data");
      $display("read done");
   endtask : rd_test
   // ======
   // Controller model
   always @(posedge hclk) begin
      rr_q <= lfsr(rr_q);
      wr_ready <= !stall && rr_q[3];
      if (rd_req === 1'b1) rd_data <= regs[rd_addr];
      if (wr_valid === 1'b1 && wr_ready) begin
         regs[wr_addr] <= wr_data;
         check(exp_q.size() > 0 && {wr_addr, wr_data} === exp_q[0], "write byte");
         if (exp_q.size() > 0) exp_q.delete(0);
      end
   end
   // ======
   // Main sequence
   initial begin
      logic [31:0] rx;
      logic [6:0] a;
      for (int i = 0; i < 128; i++) begin
         regs[i] = 8'(i) ^ 8'ha5;
         exp_reg[i] = regs[i];
      end
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(1'b0, 8'h20, 32'h0, rx);
      check(rx === 32'h0, "unmapped read");
      $display("unmapped done");
      wr_test(7'h03, 3'h4, 32'hab12cd34);
      drain("write");
      rd_test(7'h03);
      wr_test(7'h7e, 3'h4, 32'h5a6b7c8d);
      drain("wrap");
      wr_test(7'h6e, 3'h4, 32'h11223344);
      drain("fifo addr");
      rd_test(7'h6f);
      rd_test(7'h7f);
      frame(ID_CMD, 8'h3, 32'h0, rx);
      check(rx === {8'h0, DEV_ID, 16'h0}, "id byte");
      $display("id done");
      stall = 1'b1;
      wr_test(7'h20, 3'h4, 32'hf00dbeef);
      for (int i = 0; i < 300 && wr_room !== 1'b0; i++) @(posedge hclk);
      check(wr_room === 1'b0 && wr_valid === 1'b1, "buffer not full");
      stall = 1'b0;
      drain("buffer");
      for (int k = 0; k < 16; k++) begin
         lfsr_q = lfsr(lfsr_q);
         a = (lfsr_q[6:0] == 7'h7f) ? 7'h7e : lfsr_q[6:0];
         if (lfsr_q[8]) begin
            wr_test(a, {1'b0, lfsr_q[10:9]} + 3'h1, lfsr(lfsr_q));
            drain("random write");
         end else rd_test(a);
      end
      close_out();
   end
   initial begin
      #1000000;
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
   end
endmodule : testbench
